// [dv/mss_ctrl_monitor.sv]
// assertion checker on the memory-select controller ports
`timescale 1ns/1ns
`default_nettype none
`include "mss_map.svh"

module mss_ctrl_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                   i_clk_sys,           // clock
    input wire logic                   i_rst,               // sync reset
    input wire logic                   i_select_switch_two, // switch two pin
    input wire logic [`MSS_VOL_W-1:0]  i_vc_level,          // analog reading
    input wire logic [`MSS_ADDR_W-1:0] i_addr,              // address
    input wire logic [`MSS_DATA_W-1:0] i_wdata,             // write data
    input wire logic                   i_wr,                // write strobe
    input wire logic [1:0]             o_mem_sel,           // memory
    input wire logic                   o_in_mem_d_hold,     // held in D
    input wire logic [`MSS_VOL_W-1:0]  o_volume             // volume
);
    logic [7:0]  cfg;
    logic [7:0]  deb;
    logic [1:0]  vmode;
    logic [1:0]  mem_q;
    logic [1:0]  prev_mem;
    logic [15:0] open_cnt;
    logic [15:0] need_open;
    logic        closed2;

    // config is snooped so the checks follow the active mode
    assign vmode     = cfg[6:5];
    assign closed2   = i_select_switch_two ^ cfg[`MSS_CFG_POL2];
    assign need_open = (16'(deb) - 16'h1) * 16'(TICK_CYCLES);

    always_ff @(posedge i_clk_sys) begin
        mem_q <= o_mem_sel;
        open_cnt <= closed2 ? 16'h0 : ((open_cnt == 16'hffff) ? open_cnt : open_cnt + 16'h1);
        if (o_mem_sel == `MSS_MEM_D && mem_q != `MSS_MEM_D) begin
            prev_mem <= mem_q;
        end
        if (i_rst) begin
            cfg <= `MSS_CFG_RST;
            deb <= `MSS_DEB_RST;
            open_cnt <= 16'h0;
        end else if (i_wr && i_addr == `MSS_ADR_CFG) begin
            cfg <= i_wdata[7:0];
        end else if (i_wr && i_addr == `MSS_ADR_DEBOUNCE) begin
            deb <= i_wdata[7:0];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_leave_d;
        $fell(o_in_mem_d_hold);
    endsequence

    property p_reset_state;
        disable iff (1'b0) $fell(i_rst) |-> o_mem_sel == `MSS_MEM_A && !o_in_mem_d_hold && o_volume == `MSS_VOL_RST;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");

    // spacing of 3 assumes the bench tick of 4 cycles
    property p_tick_gap;
        $changed(o_mem_sel) |=> $stable(o_mem_sel) [*3];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("memory changed between ticks");

    property p_held_in_d;
        o_in_mem_d_hold |-> o_mem_sel == `MSS_MEM_D;
    endproperty
    a_held_in_d: assert property (p_held_in_d) else $error("held outside memory D");

    property p_debounce;
        s_leave_d |-> !cfg[`MSS_CFG_ATC] || deb < 8'h2 || open_cnt >= need_open;
    endproperty
    a_debounce: assert property (p_debounce) else $error("left D before debounce ran out");

    property p_return;
        s_leave_d ##0 !cfg[`MSS_CFG_KIND] |-> ##[0:1] o_mem_sel == prev_mem;
    endproperty
    a_return: assert property (p_return) else $error("wrong memory after leaving D");

    property p_vol_step;
        $past(vmode) == `MSS_VMODE_DIGITAL && vmode == `MSS_VMODE_DIGITAL && $changed(o_volume)
            |-> o_volume == $past(o_volume) + 5'h1 || o_volume == $past(o_volume) - 5'h1;
    endproperty
    a_vol_step: assert property (p_vol_step) else $error("volume moved more than one step");

    property p_analog;
        $past(vmode) == `MSS_VMODE_ANALOG |-> o_volume == $past(i_vc_level);
    endproperty
    a_analog: assert property (p_analog) else $error("volume not following analog input");

    property p_static_wr;
        i_wr && i_addr == `MSS_ADR_VOLUME && vmode[1] == vmode[0] |=> o_volume == $past(i_wdata[4:0]);
    endproperty
    a_static_wr: assert property (p_static_wr) else $error("static volume write lost");
endmodule : mss_ctrl_monitor

bind mss_ctrl mss_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES)) mss_ctrl_monitor_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_select_switch_two(i_select_switch_two),
    .i_vc_level(i_vc_level), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .o_mem_sel(o_mem_sel), .o_in_mem_d_hold(o_in_mem_d_hold), .o_volume(o_volume));

`default_nettype wire

// [dv/mss_ctrl_test.sv]
// self-checking bench for the memory-select controller
`timescale 1ns/1ns
`default_nettype none
`include "mss_map.svh"

module mss_ctrl_test;
    localparam int TICK = 4;
    localparam int W = 16;
    logic        clk;
    logic        rst;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  closed;
    logic [1:0]  pol;
    logic [3:0]  pins;
    logic [4:0]  vc;
    logic [15:0] trim;
    logic [1:0]  mem;
    logic        held;
    logic [4:0]  vol;
    logic [75:0] pv;
    int          n_mismatch;
    int          n_compared;

    mss_user_sw mss_user_sw_inst (.i_closed(closed), .i_pol(pol), .o_pins(pins));

    mss_ctrl #(.TICK_CYCLES(TICK)) mss_ctrl_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_select_switch_one(pins[0]), .i_select_switch_two(pins[1]),
        .i_volume_up_pin(pins[2]), .i_volume_down_pin(pins[3]), .i_vc_level(vc), .i_trim_pos(trim),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_mem_sel(mem),
        .o_in_mem_d_hold(held), .o_volume(vol), .o_param_val(pv));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    task automatic set_cfg(input logic [7:0] c);
        wr_reg(`MSS_ADR_CFG, {24'h0, c});
        pol <= c[3:2];
        cyc(W);
    endtask : set_cfg

    task automatic press(input int i);
        @(posedge clk);
        closed[i] <= 1'b1;
        cyc(2 * TICK);
        @(posedge clk);
        closed[i] <= 1'b0;
        cyc(3 * TICK);
    endtask : press

    task automatic set_sw(input logic [1:0] v);
        @(posedge clk);
        closed[1:0] <= v;
        cyc(W);
    endtask : set_sw

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(20000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        closed = 4'h0;
        pol = 2'h0;
        vc = 5'h07;
        trim = 16'h9a5c;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk(vol, `MSS_VOL_RST);
        rd_reg(`MSS_ADR_DEBOUNCE, 32'h10);
        rd_reg(8'h20, 32'h0);
        wr_reg(`MSS_ADR_VALID, 32'h0);
        rd_reg(`MSS_ADR_VALID, 32'h1);
        press(0);
        chk(mem, 32'h0);
        wr_reg(`MSS_ADR_VALID, 32'hf);
        for (int k = 1; k <= 4; k++) begin
            press(0);
            chk(mem, 32'(k % 4));
        end
        // invalid memory C is skipped
        wr_reg(`MSS_ADR_VALID, 32'hb);
        press(0);
        chk(mem, 32'h1);
        press(0);
        chk(mem, 32'h3);
        press(0);
        chk(mem, 32'h0);
        wr_reg(`MSS_ADR_VALID, 32'hf);
        for (int p = 0; p < 2; p++) begin
            set_cfg((p == 1) ? 8'h0d : 8'h01);
            for (int c = 0; c < 4; c++) begin
                set_sw(c[1:0]);
                chk(mem, 32'(c));
            end
        end
        wr_reg(`MSS_ADR_VALID, 32'h3);
        set_sw(2'h2);
        chk(mem, 32'h0);
        wr_reg(`MSS_ADR_VALID, 32'hf);
        set_cfg(8'h03);
        set_sw(2'h1);
        chk(mem, 32'h1);
        set_sw(2'h3);
        chk(mem, 32'h3);
        set_sw(2'h0);
        chk(mem, 32'h0);
        set_cfg(8'h02);
        press(0);
        chk(mem, 32'h1);
        set_sw(2'h2);
        chk(mem, 32'h3);
        press(0);
        chk(mem, 32'h3);
        set_sw(2'h0);
        chk(mem, 32'h1);
        press(0);
        press(0);
        chk(mem, 32'h0);
        wr_reg(`MSS_ADR_DEBOUNCE, 32'h5);
        set_cfg(8'h10);
        press(0);
        set_sw(2'h2);
        chk(held, 32'h1);
        rd_reg(`MSS_ADR_STATUS, 32'h22b);
        // short opening is cancelled by a closed sample
        @(posedge clk);
        closed[1] <= 1'b0;
        cyc(2 * TICK);
        set_sw(2'h2);
        chk(mem, 32'h3);
        @(posedge clk);
        closed[1] <= 1'b0;
        cyc(2 * TICK);
        chk(held, 32'h1);
        cyc(8 * TICK);
        chk(mem, 32'h1);
        chk(held, 32'h0);
        set_cfg(8'h40);
        press(2);
        chk(vol, 32'h11);
        press(3);
        press(3);
        chk(vol, 32'h0f);
        wr_reg(`MSS_ADR_VOLUME, 32'h5);
        cyc(2);
        chk(vol, 32'h0f);
        set_cfg(8'h20);
        chk(vol, 32'h07);
        set_cfg(8'h00);
        wr_reg(`MSS_ADR_VOLUME, 32'h1a);
        rd_reg(`MSS_ADR_VOLUME, 32'h1a);
        chk(vol, 32'h1a);
        set_cfg(8'hc0);
        press(2);
        chk(mem, 32'h2);
        chk(vol, 32'h1a);
        // one trimmer drives first and last parameter
        wr_reg(8'h88, 32'h6);
        wr_reg(`MSS_ADR_MAP0, 32'h6);
        cyc(4);
        chk(pv[75:72], 32'ha);
        chk(pv[7:0], 32'h0a);
        rd_reg(8'h88, 32'ha06);
        report_and_stop();
    end
endmodule : mss_ctrl_test

`default_nettype wire

// [dv/mss_user_sw.sv]
// user switches and pushbuttons seen as pin levels
`timescale 1ns/1ns
`default_nettype none

module mss_user_sw (
    input  wire logic [3:0] i_closed, // contacts {down,up,sw2,sw1}
    input  wire logic [1:0] i_pol,    // 1 = switch wired to ground
    output logic      [3:0] o_pins    // pin levels
);
    assign o_pins[1:0] = i_closed[1:0] ^ i_pol;
    assign o_pins[3:2] = i_closed[3:2];
endmodule : mss_user_sw

`default_nettype wire

// [hw/mss_ctrl.sv]
// memory-select switch, volume and trimmer-mapping controller
//
// Contract
// - up to four memories; memory A always counts as valid
// - four switch modes from kind and last-memory flags, mode four three memories
// - kind setting makes switches momentary presses or static levels
// - last-memory flag reserves switch two for memory D
// - per-input polarity: pulldown closed reads high, pullup closed reads low; code sets it for switches one and two only, volume buttons fixed high
// - single momentary mode starts in memory A
// - each press loads next valid memory, invalid ones skipped
// - press in last valid memory wraps back to memory A
// - auto telecoil: closing switch two enters memory D
// - after debounced opening, return to memory active before D
// - closed-to-open transition on switch two starts debounce monitoring
// - leave D only after whole debounce period open; closed sample cancels
// - digital volume: up closure raises one step, down closure lowers one
// - analog and digital volume control mutually exclusive
// - volume static from software or from external control
// - rocker optionally steps memories instead of volume
// - 19 parameters, four trimmers, 16 values, one trimmer many parameters
// - momentary-plus-static: closed switch two forces D, ignores switch one
// - static modes start at switch-selected memory, binary decode
// - static selection of invalid memory falls back to memory A
`timescale 1ns/1ns
`default_nettype none
`include "mss_map.svh"

module mss_ctrl #(
    parameter int TICK_CYCLES = `MSS_TICK_US * `MSS_CLK_MHZ
) (
    input  wire logic                                   i_clk_sys,           // system clock
    input  wire logic                                   i_rst,               // sync reset, high
    input  wire logic                                   i_select_switch_one, // switch one pin
    input  wire logic                                   i_select_switch_two, // switch two pin
    input  wire logic                                   i_volume_up_pin,     // volume up button
    input  wire logic                                   i_volume_down_pin,   // volume down button
    input  wire logic [`MSS_VOL_W-1:0]                  i_vc_level,          // analog control reading
    input  wire logic [`MSS_NUM_TRIM*`MSS_VAL_W-1:0]    i_trim_pos,          // trimmer positions
    input  wire logic [`MSS_ADDR_W-1:0]                 i_addr,              // register address
    input  wire logic [`MSS_DATA_W-1:0]                 i_wdata,             // write data
    input  wire logic                                   i_wr,                // write strobe
    input  wire logic                                   i_rd,                // read strobe
    output logic      [`MSS_DATA_W-1:0]                 o_rdata,             // read data, next cycle
    output logic      [1:0]                             o_mem_sel,           // active memory
    output logic                                        o_in_mem_d_hold,     // held in memory D
    output logic      [`MSS_VOL_W-1:0]                  o_volume,            // current volume
    output logic      [`MSS_NUM_PARAM*`MSS_VAL_W-1:0]   o_param_val          // mapped parameter values
);
    mss_pkg::mss_state_t s;
    mss_pkg::mss_state_t next_s;

    // switch levels reach the controller only through the sampler
    mss_sw_if sw ();

    mss_sampler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_sampler (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_pins    ({i_volume_down_pin,
                     i_volume_up_pin,
                     i_select_switch_two,
                     i_select_switch_one}),
        .i_pol     ({2'h0, s.cfg[`MSS_CFG_POL2], s.cfg[`MSS_CFG_POL1]}),
        .sw        (sw.src)
    );

    // walk from cur in one direction to the next allowed memory, A if none
    function automatic logic [1:0] mss_step(
        input logic [1:0] cur,
        input logic [3:0] ok,
        input logic       up
    );
        logic [1:0] c;
        logic [1:0] r;
        logic       found;
        c     = cur;
        r     = `MSS_MEM_A;
        found = 1'b0;
        // three steps at most: memory A is always valid, so the walk ends
        for (int i = 0; i < `MSS_NUM_MEM - 1; i++) begin
            c = up ? c + 2'h1 : c - 2'h1;
            if (ok[c] && !found) begin
                r     = c;
                found = 1'b1;
            end
        end
        return r;
    endfunction : mss_step

    logic [`MSS_NUM_PARAM-1:0][`MSS_VAL_W-1:0] trim_sel;
    // trimmer index uses the low two map bits
    genvar gp;
    generate
        for (gp = 0; gp < `MSS_NUM_PARAM; gp++) begin : g_param
            assign trim_sel[gp] = i_trim_pos[s.map[gp][1:0]*`MSS_VAL_W +: `MSS_VAL_W];
        end
    endgenerate

    // configuration fields decoded once for all processes
    logic                      kind_static;
    logic                      d_only;
    logic                      atc;
    logic [1:0]                vmode;
    logic                      rocker;
    logic [`MSS_NUM_MEM-1:0]   valid_eff;
    logic [`MSS_NUM_MEM-1:0]   step_ok;
    logic [1:0]                stat_sel;
    logic [`MSS_ADDR_W-1:0]    map_off;
    logic [`MSS_ADDR_W-3:0]    map_idx;
    logic                      map_hit;

    always_comb begin
        kind_static = s.cfg[`MSS_CFG_KIND];
        d_only      = s.cfg[`MSS_CFG_DONLY];
        atc         = s.cfg[`MSS_CFG_ATC];
        vmode       = s.cfg[`MSS_CFG_VMODE +: 2];
        rocker      = s.cfg[`MSS_CFG_ROCKER];

        valid_eff   = s.valid | `MSS_VALID_RST;

        // memory D is not in the stepping set when reserved
        step_ok     = (d_only || atc) ? (valid_eff & 4'h7) : valid_eff;

        // binary decode of the two static switches
        stat_sel    = d_only ? {1'b0, sw.closed[`MSS_PIN_SW1]}
                             : {sw.closed[`MSS_PIN_SW2], sw.closed[`MSS_PIN_SW1]};

        // map registers sit on word addresses above the map base
        map_off     = i_addr - `MSS_ADR_MAP0;
        map_idx     = map_off[`MSS_ADDR_W-1:2];
        map_hit     = (i_addr >= `MSS_ADR_MAP0) && (map_off[1:0] == 2'h0)
                      && (map_idx < (`MSS_ADDR_W-2)'(`MSS_NUM_PARAM));
    end

    always_comb begin
        next_s       = s;
        // read data lives one cycle, then falls back to zero
        next_s.rdata = '0;

        // register writes
        if (i_wr) begin
            case (i_addr)
                `MSS_ADR_CFG: begin
                    next_s.cfg = i_wdata[`MSS_CFG_W-1:0];
                end
                `MSS_ADR_VALID: begin
                    next_s.valid = i_wdata[`MSS_NUM_MEM-1:0];
                end
                `MSS_ADR_DEBOUNCE: begin
                    next_s.deb_per = i_wdata[`MSS_DEB_W-1:0];
                end
                `MSS_ADR_VOLUME: begin
                    // dropped in analog or digital mode: the pins own the volume
                    // static volume from software
                    if (vmode != `MSS_VMODE_ANALOG && vmode != `MSS_VMODE_DIGITAL) begin
                        next_s.vol = i_wdata[`MSS_VOL_W-1:0];
                    end
                end
                default: begin
                    if (map_hit) begin
                        next_s.map[map_idx] = i_wdata[`MSS_MAP_W-1:0];
                    end
                end
            endcase
        end

        // register reads, data stands one cycle later
        if (i_rd) begin
            case (i_addr)
                `MSS_ADR_CFG:      next_s.rdata = {24'h000000, s.cfg};
                `MSS_ADR_VALID:    next_s.rdata = {28'h0000000, valid_eff};
                `MSS_ADR_DEBOUNCE: next_s.rdata = {24'h000000, s.deb_per};
                `MSS_ADR_VOLUME:   next_s.rdata = {27'h0000000, s.vol};
                `MSS_ADR_STATUS: begin
                    next_s.rdata[1:0]  = s.mem;
                    next_s.rdata[3]    = (s.fsm != mss_pkg::MSS_NORMAL);
                    next_s.rdata[6:4]  = s.fsm;
                    next_s.rdata[11:8] = sw.closed;
                end
                default: begin
                    if (map_hit) begin
                        next_s.rdata[2:0]  = s.map[map_idx];
                        next_s.rdata[11:8] = s.param[map_idx];
                    end
                end
            endcase
        end

        // memory selection, decided once per sample tick
        // bounce inside one tick period is never seen
        if (sw.tick) begin
            case (s.fsm)
                mss_pkg::MSS_NORMAL: begin
                    // closing switch two enters memory D
                    // forced D at startup or in operation
                    if ((d_only || atc) && sw.closed[`MSS_PIN_SW2]) begin
                        next_s.prev = s.mem;
                        next_s.mem  = `MSS_MEM_D;
                        next_s.fsm  = mss_pkg::MSS_HOLD_D;
                    end else if (kind_static) begin
                        // invalid selection falls back to A
                        next_s.mem = valid_eff[stat_sel] ? stat_sel : `MSS_MEM_A;
                    end else if (sw.press[`MSS_PIN_SW1]) begin
                        // wrap to memory A after the last valid one
                        next_s.mem = mss_step(s.mem, step_ok, 1'b1);
                    end else if (vmode == `MSS_VMODE_DIGITAL && rocker) begin
                        // volume then stays put: the pins step memories and software writes are dropped
                        // rocker steps memories both ways
                        if (sw.press[`MSS_PIN_UP]) begin
                            next_s.mem = mss_step(s.mem, step_ok, 1'b1);
                        end else if (sw.press[`MSS_PIN_DOWN]) begin
                            next_s.mem = mss_step(s.mem, step_ok, 1'b0);
                        end
                    end
                end
                mss_pkg::MSS_HOLD_D: begin
                    // switch one ignored while held in D
                    if (!sw.closed[`MSS_PIN_SW2]) begin
                        if (atc) begin
                            next_s.deb = '0;
                            next_s.fsm = mss_pkg::MSS_DEBOUNCE;
                        end else begin
                            // a static switch without telecoil returns at once
                            next_s.mem = s.prev;
                            next_s.fsm = mss_pkg::MSS_NORMAL;
                        end
                    end
                end
                mss_pkg::MSS_DEBOUNCE: begin
                    // counted in ticks; the first open tick only arms the count
                    // any closed sample cancels the exit
                    if (sw.closed[`MSS_PIN_SW2]) begin
                        next_s.fsm = mss_pkg::MSS_HOLD_D;
                    end else if (s.deb + `MSS_DEB_W'(1) >= s.deb_per) begin
                        // back to the memory before D
                        next_s.mem = s.prev;
                        next_s.fsm = mss_pkg::MSS_NORMAL;
                    end else begin
                        next_s.deb = s.deb + `MSS_DEB_W'(1);
                    end
                end
                default: begin
                    // an illegal code recovers to normal operation
                    next_s.fsm = mss_pkg::MSS_NORMAL;
                end
            endcase
        end

        // one volume source at a time, chosen by one field
        if (vmode == `MSS_VMODE_ANALOG) begin
            next_s.vol = i_vc_level;
        end else if (vmode == `MSS_VMODE_DIGITAL && !rocker && sw.tick) begin
            // no wrap at the ends: a press at the limit is dropped
            // one step per closure, saturating
            if (sw.press[`MSS_PIN_UP] && s.vol != `MSS_VOL_MAX) begin
                next_s.vol = s.vol + `MSS_VOL_W'(1);
            end else if (sw.press[`MSS_PIN_DOWN] && s.vol != `MSS_VOL_MIN) begin
                next_s.vol = s.vol - `MSS_VOL_W'(1);
            end
        end

        // unmapped parameters keep their last value
        // one trimmer may feed many parameters
        for (int p = 0; p < `MSS_NUM_PARAM; p++) begin
            if (s.map[p][`MSS_MAP_EN]) begin
                next_s.param[p] = trim_sel[p];
            end
        end
    end

    // one register for all state keeps reset and update together
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s         <= '0;
            s.fsm     <= mss_pkg::MSS_NORMAL;
            s.mem     <= `MSS_MEM_A;
            s.cfg     <= `MSS_CFG_RST;
            s.valid   <= `MSS_VALID_RST;
            s.deb_per <= `MSS_DEB_RST;
            s.vol     <= `MSS_VOL_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs come straight from the flops, the hold flag through a compare of the state
    assign o_rdata         = s.rdata;
    assign o_mem_sel       = s.mem;
    assign o_in_mem_d_hold = (s.fsm != mss_pkg::MSS_NORMAL);
    assign o_volume        = s.vol;
    assign o_param_val     = s.param;

endmodule : mss_ctrl

`default_nettype wire

// [hw/mss_map.svh]
// register map, field positions, reset values and timing constants of the memory-select controller
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH

`define MSS_ADDR_W        8
`define MSS_DATA_W        32

`define MSS_ADR_CFG       8'h00
`define MSS_ADR_VALID     8'h04
`define MSS_ADR_DEBOUNCE  8'h08
`define MSS_ADR_VOLUME    8'h0c
`define MSS_ADR_STATUS    8'h10
`define MSS_ADR_MAP0      8'h40

`define MSS_CFG_W         8
`define MSS_CFG_RST       8'h00
`define MSS_CFG_KIND      0
`define MSS_CFG_DONLY     1
`define MSS_CFG_POL1      2
`define MSS_CFG_POL2      3
`define MSS_CFG_ATC       4
`define MSS_CFG_VMODE     5
`define MSS_CFG_ROCKER    7

`define MSS_VMODE_STATIC  2'h0
`define MSS_VMODE_ANALOG  2'h1
`define MSS_VMODE_DIGITAL 2'h2

`define MSS_NUM_MEM       4
`define MSS_VALID_RST     4'h1
`define MSS_MEM_A         2'h0
`define MSS_MEM_D         2'h3
`define MSS_DEB_W         8
`define MSS_DEB_RST       8'h10

`define MSS_VOL_W         5
`define MSS_VOL_RST       5'h10
`define MSS_VOL_MAX       5'h1f
`define MSS_VOL_MIN       5'h00

`define MSS_NUM_PARAM     19
`define MSS_NUM_TRIM      4
`define MSS_VAL_W         4
`define MSS_MAP_W         3
`define MSS_MAP_EN        2

`define MSS_PIN_SW1       0
`define MSS_PIN_SW2       1
`define MSS_PIN_UP        2
`define MSS_PIN_DOWN      3
`define MSS_NUM_PIN       4

`define MSS_TICK_US       1000
`define MSS_CLK_MHZ       20
`define MSS_TICK_CNT_W    16

`endif

// [hw/mss_pkg.sv]
// types shared by the memory-select controller modules
`include "mss_map.svh"

package mss_pkg;

    typedef enum logic [2:0] {
        MSS_NORMAL   = 3'b001,
        MSS_HOLD_D   = 3'b010,
        MSS_DEBOUNCE = 3'b100
    } mss_fsm_t;

    typedef struct packed {
        mss_fsm_t                                    fsm;
        logic [1:0]                                  mem;
        logic [1:0]                                  prev;
        logic [`MSS_DEB_W-1:0]                       deb;
        logic [`MSS_DEB_W-1:0]                       deb_per;
        logic [`MSS_CFG_W-1:0]                       cfg;
        logic [`MSS_NUM_MEM-1:0]                     valid;
        logic [`MSS_VOL_W-1:0]                       vol;
        logic [`MSS_NUM_PARAM-1:0][`MSS_MAP_W-1:0]   map;
        logic [`MSS_NUM_PARAM-1:0][`MSS_VAL_W-1:0]   param;
        logic [`MSS_DATA_W-1:0]                      rdata;
    } mss_state_t;

    typedef struct packed {
        logic [`MSS_NUM_PIN-1:0]    sync1;
        logic [`MSS_NUM_PIN-1:0]    sync2;
        logic [`MSS_NUM_PIN-1:0]    lvl;
        logic [`MSS_NUM_PIN-1:0]    press;
        logic                       tick;
        logic [`MSS_TICK_CNT_W-1:0] cnt;
    } mss_smp_t;

endpackage : mss_pkg

// [hw/mss_sampler.sv]
// pin synchroniser, slow sample tick, polarity correction and press detection
`timescale 1ns/1ns
`default_nettype none
`include "mss_map.svh"

module mss_sampler #(
    parameter int TICK_CYCLES = 20000
) (
    input  wire logic                    i_clk_sys, // system clock
    input  wire logic                    i_rst,     // sync reset, high
    input  wire logic [`MSS_NUM_PIN-1:0] i_pins,    // raw pin levels
    input  wire logic [`MSS_NUM_PIN-1:0] i_pol,     // 1 = pullup wiring
    mss_sw_if.src                        sw         // sampled switch view
);
    mss_pkg::mss_smp_t s;
    mss_pkg::mss_smp_t next_s;

    always_comb begin
        next_s       = s;
        next_s.sync1 = i_pins;
        next_s.sync2 = s.sync1;
        next_s.tick  = 1'b0;
        next_s.press = '0;
        if (s.cnt >= `MSS_TICK_CNT_W'(TICK_CYCLES - 1)) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
            next_s.lvl   = s.sync2 ^ i_pol;
            next_s.press = (s.sync2 ^ i_pol) & ~s.lvl;
        end else begin
            next_s.cnt = s.cnt + `MSS_TICK_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sw.closed = s.lvl;
    assign sw.press  = s.press;
    assign sw.tick   = s.tick;

endmodule : mss_sampler

`default_nettype wire

// [hw/mss_sw_if.sv]
// sampled switch levels, press pulses and sample tick between sampler and controller
`timescale 1ns/1ns
`default_nettype none
`include "mss_map.svh"

interface mss_sw_if;
    logic [`MSS_NUM_PIN-1:0] closed;
    logic [`MSS_NUM_PIN-1:0] press;
    logic                    tick;

    modport src (output closed, output press, output tick);
    modport dst (input closed, input press, input tick);
endinterface : mss_sw_if

`default_nettype wire
